// file: pes_pkg.sv
// pes_pkg: constants for the performance event source encoder.
// assumes a single core clock domain; nothing here is synthesised alone.
package pes_pkg;

  // event selector width and code range
  localparam int          SEL_W        = 6;
  localparam logic [5:0]  EV_NONE      = 6'h00;
  localparam logic [5:0]  EV_FIRST     = 6'h0f;  // lowest code handled here
  localparam logic [5:0]  EV_MAX       = 6'h32;  // highest code, 50

  // event codes handled by this block
  localparam logic [5:0]  EV_ALU       = 6'h0f;
  localparam logic [5:0]  EV_CSR_RD    = 6'h10;
  localparam logic [5:0]  EV_CSR_RW    = 6'h11;
  localparam logic [5:0]  EV_CSR_WR0   = 6'h12;
  localparam logic [5:0]  EV_EBREAK    = 6'h13;
  localparam logic [5:0]  EV_MRET      = 6'h17;
  localparam logic [5:0]  EV_BR        = 6'h18;
  localparam logic [5:0]  EV_BR_UNPRED = 6'h1b;
  localparam logic [5:0]  EV_FETCH_STL = 6'h1c;
  localparam logic [5:0]  EV_IDIS_STL  = 6'h32;

  // counter layout
  localparam int          CNT_W        = 64;
  localparam int          NUM_CNT      = 4;
  localparam int          FIRST_CNT    = 3;   // counters 3..6 are live
  localparam logic        GRP_EN_RST   = 1'b1;
  localparam logic [63:0] CNT_RST      = 64'h0000_0000_0000_0000;

endpackage

// file: pes_encoder.sv
// pes_encoder: maps event codes 15..50 onto core conditions and advances
// four 64-bit event counters by the per-cycle increment of each selection.
// assumes all condition inputs come from logic on clk_sys (no synchroniser)
// and that selector/counter writes are decoded by the csr unit outside.
//
// Operation
// - code 15 adds committed alu ops, 0..2
// - nops and wfi count as alu ops
// - codes 16-18 count csr read, rw, write-rd0
// - codes 19-23 ebreak ecall fence fence.i mret
// - codes 24-27 branch, mispredict, taken, unpredictable
// - code 28 fetch ready but stalled cycles
// - code 29 aligner valid, instruction buffer full
// - code 30 buffer valid but decode stalled
// - codes 31-32 postsync and presync decode stalls
// - code 33 load-store pipe freeze cycles
// - code 34 store or write buffer full
// - codes 35-36 dma data and instruction stalls
// - codes 37-39 exceptions, timer, external interrupts
// - codes 40-41 trap flushes, branch error flushes
// - codes 42-44 bus transaction counts
// - codes 45-46 instruction and data bus errors
// - codes 47-48 instruction/data bus busy stalls
// - codes 49-50 interrupts disabled, stalled while disabled
// - selector clamps oversize writes to highest code
// - only counters three to six are live
// - group enable resets one, gates increments
`timescale 1ns/1ps

module pes_encoder #(
  parameter int NUM_CNT = pes_pkg::NUM_CNT
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // commit qualification
  input  wire logic                       commit_valid,
  input  wire logic                       trap_valid,
  input  wire logic [1:0]                 alu_commit_cnt,
  input  wire logic [1:0]                 nop_commit_cnt,
  input  wire logic                       csr_rd_commit,
  input  wire logic                       csr_rw_commit,
  input  wire logic                       csr_wr0_commit,
  input  wire logic                       ebreak_commit,
  input  wire logic                       ecall_commit,
  input  wire logic                       fence_commit,
  input  wire logic                       fencei_commit,
  input  wire logic                       mret_commit,
  input  wire logic                       br_commit,
  input  wire logic                       br_mispred,
  input  wire logic                       br_taken,
  input  wire logic                       br_unpred,
  // trap and flush events
  input  wire logic                       exc_taken,
  input  wire logic                       timer_int_taken,
  input  wire logic                       ext_int_taken,
  input  wire logic                       trap_control_unit_flush,
  input  wire logic                       br_error_flush,
  // out-of-pipe stall conditions
  input  wire logic                       fetch_stall,
  input  wire logic                       aligner_stall,
  input  wire logic                       decode_stall,
  input  wire logic                       postsync_stall,
  input  wire logic                       presync_stall,
  input  wire logic                       loadstore_pipe_freeze,
  input  wire logic                       store_buffer_full,
  input  wire logic                       write_buffer_full,
  input  wire logic                       dma_dmem_stall,
  input  wire logic                       dma_imem_stall,
  // bus conditions
  input  wire logic                       ibus_trans,
  input  wire logic                       dbus_trans,
  input  wire logic                       dbus_misaligned,
  input  wire logic                       ibus_error,
  input  wire logic                       dbus_error,
  input  wire logic                       ibus_busy_stall,
  input  wire logic                       dbus_busy_stall,
  // interrupt enable state
  input  wire logic                       mie_clear,
  input  wire logic                       int_pending,
  // selector and group enable writes
  input  wire logic [NUM_CNT-1:0]         sel_wr,
  input  wire logic [31:0]                sel_wdata,
  input  wire logic                       grp_en_wr,
  input  wire logic                       grp_en_wdata,
  // counter writes
  input  wire logic [NUM_CNT-1:0]         cnt_wr,
  input  wire logic [63:0]                cnt_wdata,
  // visible state
  output logic [NUM_CNT-1:0][5:0]         sel,
  output logic [NUM_CNT-1:0][63:0]        cnt,
  output logic                            grp_en
);

  // qualified per-code increments, indexed by code (0 .. 50)
  logic [50:0][1:0] inc;            // increment per event code
  logic             ip_ok;          // in-pipe qualifier
  logic [2:0]       alu_sum;        // alu plus nop count, wide for sum

  // build the increment table; codes below 15 are outside this block
  always_comb begin
    ip_ok   = commit_valid | trap_valid;
    alu_sum = {1'b0, alu_commit_cnt} + {1'b0, nop_commit_cnt};
    inc     = '0;
    // alu count saturates at the two-wide commit limit
    inc[15] = (!commit_valid) ? 2'd0 :
              (alu_sum > 3'd2) ? 2'd2 : alu_sum[1:0];
    inc[16] = {1'b0, commit_valid & csr_rd_commit};
    inc[17] = {1'b0, commit_valid & csr_rw_commit};
    inc[18] = {1'b0, commit_valid & csr_wr0_commit};
    inc[19] = {1'b0, commit_valid & ebreak_commit};
    inc[20] = {1'b0, commit_valid & ecall_commit};
    inc[21] = {1'b0, commit_valid & fence_commit};
    inc[22] = {1'b0, commit_valid & fencei_commit};
    inc[23] = {1'b0, commit_valid & mret_commit};
    inc[24] = {1'b0, commit_valid & br_commit};
    inc[25] = {1'b0, commit_valid & br_mispred};
    inc[26] = {1'b0, commit_valid & br_taken};
    inc[27] = {1'b0, commit_valid & br_unpred};
    // out-of-pipe conditions are taken as they stand
    inc[28] = {1'b0, fetch_stall};
    inc[29] = {1'b0, aligner_stall};
    inc[30] = {1'b0, decode_stall};
    inc[31] = {1'b0, postsync_stall};
    inc[32] = {1'b0, presync_stall};
    inc[33] = {1'b0, loadstore_pipe_freeze};
    inc[34] = {1'b0, store_buffer_full | write_buffer_full};
    inc[35] = {1'b0, dma_dmem_stall};
    inc[36] = {1'b0, dma_imem_stall};
    // trap-side events ride on the in-pipe qualifier, commit or trap valid
    inc[37] = {1'b0, ip_ok & exc_taken};
    inc[38] = {1'b0, ip_ok & timer_int_taken};
    inc[39] = {1'b0, ip_ok & ext_int_taken};
    inc[40] = {1'b0, ip_ok & trap_control_unit_flush};
    inc[41] = {1'b0, ip_ok & br_error_flush};
    inc[42] = {1'b0, ibus_trans};
    inc[43] = {1'b0, dbus_trans};
    inc[44] = {1'b0, dbus_misaligned};
    inc[45] = {1'b0, ibus_error};
    inc[46] = {1'b0, dbus_error};
    inc[47] = {1'b0, ibus_busy_stall};
    inc[48] = {1'b0, dbus_busy_stall};
    inc[49] = {1'b0, mie_clear};
    inc[50] = {1'b0, mie_clear & int_pending};
  end

  // group enable: software writes the value, resets enabled
  logic next_grp_en;
  always_comb begin
    next_grp_en = grp_en_wr ? grp_en_wdata : grp_en;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      grp_en <= pes_pkg::GRP_EN_RST;
    end else begin
      grp_en <= next_grp_en;
    end
  end

  // one selector and one counter per live slot (counters 3..6)
  logic [NUM_CNT-1:0][5:0]  next_sel;
  logic [NUM_CNT-1:0][63:0] next_cnt;

  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    logic [1:0] step;   // increment picked by this slot's selector

    // selector is warl: oversize values clamp to the top code
    always_comb begin
      next_sel[g] = sel[g];
      if (sel_wr[g]) begin
        if (sel_wdata > 32'(pes_pkg::EV_MAX)) begin
          next_sel[g] = pes_pkg::EV_MAX;
        end else begin
          next_sel[g] = sel_wdata[5:0];
        end
      end
    end

    // codes below 15 are handled elsewhere, so they add nothing here
    always_comb begin
      if (sel[g] < pes_pkg::EV_FIRST || sel[g] > pes_pkg::EV_MAX) begin
        step = 2'd0;
      end else begin
        step = inc[sel[g]];
      end
    end

    // a software write wins; counting is held off while disabled
    always_comb begin
      if (cnt_wr[g]) begin
        next_cnt[g] = cnt_wdata;
      end else if (grp_en) begin
        next_cnt[g] = cnt[g] + 64'(step);
      end else begin
        next_cnt[g] = cnt[g];
      end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        sel[g] <= pes_pkg::EV_NONE;
        cnt[g] <= pes_pkg::CNT_RST;
      end else begin
        sel[g] <= next_sel[g];
        cnt[g] <= next_cnt[g];
      end
    end
  end
  // counters 7..31 simply do not exist here and read zero outside

  // checks: slot 0 is the slot that walks through every code in use,
  // so most properties watch it; the clamp is exercised on slot 3
  property p_clamp;
    @(posedge clk_sys) disable iff (rst)
    (sel_wr[3] && sel_wdata > 32'(pes_pkg::EV_MAX))
    |=> sel[3] == pes_pkg::EV_MAX;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("selector not clamped");

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
    (!grp_en && !cnt_wr[0]) |=> $stable(cnt[0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved while off");

  property p_alu;
    @(posedge clk_sys) disable iff (rst)
    (grp_en && !cnt_wr[0] && sel[0] == pes_pkg::EV_ALU && commit_valid
     && alu_commit_cnt == 2'h2 && nop_commit_cnt == 2'h0)
    |=> cnt[0] == $past(cnt[0]) + 64'h2;
  endproperty
  a_alu: assert property (p_alu)
    else $error("alu count wrong");

  property p_nop;
    @(posedge clk_sys) disable iff (rst)
    (grp_en && !cnt_wr[0] && sel[0] == pes_pkg::EV_ALU && commit_valid
     && alu_commit_cnt == 2'h0 && nop_commit_cnt == 2'h1)
    |=> cnt[0] == $past(cnt[0]) + 64'h1;
  endproperty
  a_nop: assert property (p_nop)
    else $error("nop not counted");

  property p_csr_ip;
    @(posedge clk_sys) disable iff (rst)
    (!cnt_wr[0] && sel[0] == pes_pkg::EV_CSR_RD && !commit_valid)
    |=> $stable(cnt[0]);
  endproperty
  a_csr_ip: assert property (p_csr_ip)
    else $error("csr counted uncommitted");

  property p_br_ip;
    @(posedge clk_sys) disable iff (rst)
    (!cnt_wr[0] && sel[0] == pes_pkg::EV_BR && !commit_valid)
    |=> $stable(cnt[0]);
  endproperty
  a_br_ip: assert property (p_br_ip)
    else $error("branch counted uncommitted");

  property p_trap_ip;
    @(posedge clk_sys) disable iff (rst)
    (!cnt_wr[0] && sel[0] == 6'h25 && !commit_valid && !trap_valid)
    |=> $stable(cnt[0]);
  endproperty
  a_trap_ip: assert property (p_trap_ip)
    else $error("exception counted without qualifier");

  property p_fetch;
    @(posedge clk_sys) disable iff (rst)
    (grp_en && !cnt_wr[0] && sel[0] == pes_pkg::EV_FETCH_STL && fetch_stall)
    |=> cnt[0] == $past(cnt[0]) + 64'h1;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch stall missed");

  property p_freeze;
    @(posedge clk_sys) disable iff (rst)
    (grp_en && !cnt_wr[0] && sel[0] == 6'h21 && loadstore_pipe_freeze)
    |=> cnt[0] == $past(cnt[0]) + 64'h1;
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("freeze missed");

  property p_sbwb;
    @(posedge clk_sys) disable iff (rst)
    (grp_en && !cnt_wr[0] && sel[0] == 6'h22 && write_buffer_full)
    |=> cnt[0] == $past(cnt[0]) + 64'h1;
  endproperty
  a_sbwb: assert property (p_sbwb)
    else $error("buffer stall missed");

  property p_zero;
    @(posedge clk_sys) disable iff (rst)
    (!cnt_wr[0] && sel[0] < pes_pkg::EV_FIRST)
    |=> $stable(cnt[0]);
  endproperty
  a_zero: assert property (p_zero)
    else $error("low code counted");

  property p_idis;
    @(posedge clk_sys) disable iff (rst)
    (grp_en && !cnt_wr[0] && sel[0] == pes_pkg::EV_IDIS_STL && !mie_clear)
    |=> $stable(cnt[0]);
  endproperty
  a_idis: assert property (p_idis)
    else $error("code 50 miscounted");

  property p_grp_wr;
    @(posedge clk_sys) disable iff (rst)
    grp_en_wr |=> grp_en == $past(grp_en_wdata);
  endproperty
  a_grp_wr: assert property (p_grp_wr)
    else $error("group enable write lost");

endmodule // pes_encoder

// file: pes_core_model.sv
// pes_core_model: behavioural stand-in for the pipeline, bus and trap logic.
// assumes the bench picks one event id per cycle; 0 means a quiet cycle.
`timescale 1ns/1ps

module pes_core_model (
  // event id raised this cycle, 51 = write buffer full
  input  wire logic [5:0]   ev,
  // one condition line per event id
  output logic      [51:16] cond
);
  // one-hot raise; code 50 also needs the enable-cleared line, since a
  // pending interrupt only stalls while the enable is cleared
  always_comb begin
    cond = 36'h0_0000_0000;
    if (ev >= 6'h10 && ev <= 6'h33) begin
      cond[ev] = 1'b1;
    end
    if (ev == 6'h32) begin
      cond[49] = 1'b1;
    end
  end
endmodule // pes_core_model

// file: perf_event_source_encoder_bench.sv
// perf_event_source_encoder_bench: self-checking bench for pes_encoder.
// assumes pes_pkg and pes_core_model are compiled first.
`timescale 1ns/1ps

module perf_event_source_encoder_bench;
  // one row: selector code, raised event, qualifiers, alu/nop, increment
  typedef struct packed {
    logic [5:0] code;
    logic [5:0] stim;
    logic       cv;
    logic       tv;
    logic [1:0] alu;
    logic [1:0] nop;
    logic [1:0] inc;
  } pes_row_t;

  // clock, reset and stimulus
  logic                                clk_sys;
  logic                                rst;
  pes_row_t                            cur;
  pes_row_t                            rows[$];
  logic [3:0]                          sel_wr;
  logic [31:0]                         sel_wdata;
  logic                                grp_en_wr;
  logic                                grp_en_wdata;
  logic [3:0]                          cnt_wr;
  logic [63:0]                         cnt_wdata;
  // observed state
  logic [51:16]                        cond;
  logic [pes_pkg::NUM_CNT-1:0][5:0]    sel;
  logic [pes_pkg::NUM_CNT-1:0][63:0]   cnt;
  logic                                grp_en;
  // bookkeeping
  int                                  failures;
  int                                  comparisons;
  int                                  cycles;
  logic [31:0]                         clamp_in[4];
  logic [5:0]                          clamp_out[4];

  pes_core_model pes_core_model_i (.ev(cur.stim), .cond(cond));

  // every event line except the commit/trap qualifiers and alu/nop counts comes from the model, so no input is tied off
  pes_encoder pes_encoder_i (
    .clk_sys(clk_sys), .rst(rst), .commit_valid(cur.cv),
    .trap_valid(cur.tv), .alu_commit_cnt(cur.alu), .nop_commit_cnt(cur.nop),
    .csr_rd_commit(cond[16]), .csr_rw_commit(cond[17]),
    .csr_wr0_commit(cond[18]), .ebreak_commit(cond[19]),
    .ecall_commit(cond[20]), .fence_commit(cond[21]),
    .fencei_commit(cond[22]), .mret_commit(cond[23]),
    .br_commit(cond[24]), .br_mispred(cond[25]), .br_taken(cond[26]),
    .br_unpred(cond[27]), .fetch_stall(cond[28]),
    .aligner_stall(cond[29]), .decode_stall(cond[30]),
    .postsync_stall(cond[31]), .presync_stall(cond[32]),
    .loadstore_pipe_freeze(cond[33]), .store_buffer_full(cond[34]),
    .dma_dmem_stall(cond[35]), .dma_imem_stall(cond[36]),
    .exc_taken(cond[37]), .timer_int_taken(cond[38]),
    .ext_int_taken(cond[39]), .trap_control_unit_flush(cond[40]),
    .br_error_flush(cond[41]), .ibus_trans(cond[42]),
    .dbus_trans(cond[43]), .dbus_misaligned(cond[44]),
    .ibus_error(cond[45]), .dbus_error(cond[46]),
    .ibus_busy_stall(cond[47]), .dbus_busy_stall(cond[48]),
    .mie_clear(cond[49]), .int_pending(cond[50]),
    .write_buffer_full(cond[51]), .sel_wr(sel_wr), .sel_wdata(sel_wdata),
    .grp_en_wr(grp_en_wr), .grp_en_wdata(grp_en_wdata), .cnt_wr(cnt_wr),
    .cnt_wdata(cnt_wdata), .sel(sel), .cnt(cnt), .grp_en(grp_en));

  // compare and count; x never passes for a match
  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                       input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // report and stop; the only exit of the run
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // selector on slot 0, counter cleared, then the event held 3 cycles
  task automatic run_row(input pes_row_t r);
    @(negedge clk_sys);
    sel_wr = 4'h1;
    sel_wdata = 32'(r.code);
    cnt_wr = 4'h1;
    cnt_wdata = 64'h0;
    @(negedge clk_sys);
    sel_wr = 4'h0;
    cnt_wr = 4'h0;
    cur = r;
    repeat (3) @(negedge clk_sys);
    cur = '0;
    check(cnt[0], 64'(3 * r.inc), "row count");
  endtask

  // 4 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // hang guard: the whole run needs well under 1000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("wrong value at %0t: timeout", $time);
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    cur = '0;
    {sel_wr, sel_wdata, grp_en_wr, grp_en_wdata} = '0;
    {cnt_wr, cnt_wdata} = '0;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    check(grp_en, 1'b1, "group enable reset");
    check(cnt[3], 64'h0, "counter reset");
    // plain in-pipe and out-of-pipe events, each counted once per cycle
    for (int c = 16; c <= 50; c++) begin
      rows.push_back('{6'(c), 6'(c), 1'b1, 1'b0, 2'h0, 2'h0, 2'h1});
    end
    rows.push_back('{6'h0f, 6'h00, 1'b1, 1'b0, 2'h2, 2'h0, 2'h2});
    rows.push_back('{6'h0f, 6'h00, 1'b1, 1'b0, 2'h1, 2'h1, 2'h2});
    rows.push_back('{6'h0f, 6'h00, 1'b1, 1'b0, 2'h0, 2'h1, 2'h1});
    rows.push_back('{6'h0f, 6'h00, 1'b1, 1'b0, 2'h2, 2'h2, 2'h2});
    rows.push_back('{6'h0f, 6'h00, 1'b0, 1'b0, 2'h2, 2'h0, 2'h0});
    rows.push_back('{6'h18, 6'h18, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0});
    rows.push_back('{6'h25, 6'h25, 1'b0, 1'b1, 2'h0, 2'h0, 2'h1});
    rows.push_back('{6'h1c, 6'h1c, 1'b0, 1'b0, 2'h0, 2'h0, 2'h1});
    rows.push_back('{6'h1c, 6'h1d, 1'b1, 1'b0, 2'h0, 2'h0, 2'h0});
    rows.push_back('{6'h22, 6'h33, 1'b1, 1'b0, 2'h0, 2'h0, 2'h1});
    rows.push_back('{6'h32, 6'h31, 1'b1, 1'b0, 2'h0, 2'h0, 2'h0});
    rows.push_back('{6'h10, 6'h10, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0});
    rows.push_back('{6'h25, 6'h25, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0});
    rows.push_back('{6'h00, 6'h1c, 1'b1, 1'b0, 2'h2, 2'h0, 2'h0});
    rows.push_back('{6'h05, 6'h00, 1'b1, 1'b0, 2'h2, 2'h0, 2'h0});
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    check(cnt[3], 64'h0, "idle slot counted");
    $display("test table done");
    // oversize selector writes settle on the highest code
    clamp_in = '{32'h0000_0033, 32'h8000_0010, 32'h0000_0032, 32'h0000_0031};
    clamp_out = '{6'h32, 6'h32, 6'h32, 6'h31};
    foreach (clamp_in[i]) begin
      @(negedge clk_sys);
      sel_wr = 4'h8;
      sel_wdata = clamp_in[i];
      @(negedge clk_sys);
      sel_wr = 4'h0;
      check(sel[3], clamp_out[i], "selector clamp");
    end
    $display("test clamp done");
    // all four live slots count the same stall side by side
    @(negedge clk_sys);
    sel_wr = 4'hf;
    sel_wdata = 32'h0000_001c;
    cnt_wr = 4'hf;
    cnt_wdata = 64'h0000_0000_0000_0000;
    @(negedge clk_sys);
    {sel_wr, cnt_wr} = '0;
    cur.stim = 6'h1c;
    repeat (2) @(negedge clk_sys);
    cur.stim = 6'h00;
    for (int g = 0; g < 4; g++) begin
      check(cnt[g], 64'h0000_0000_0000_0002, "live slot count");
    end
    $display("test slots done");
    // disable the group, counting stops but values stay
    @(negedge clk_sys);
    sel_wr = 4'h2;
    sel_wdata = 32'h0000_001c;
    cnt_wr = 4'h2;
    cnt_wdata = 64'h0000_0000_ffff_fffe;
    grp_en_wr = 1'b1;
    grp_en_wdata = 1'b0;
    @(negedge clk_sys);
    {sel_wr, cnt_wr, grp_en_wr} = '0;
    cur.stim = 6'h1c;
    repeat (3) @(negedge clk_sys);
    check(cnt[1], 64'h0000_0000_ffff_fffe, "count while off");
    grp_en_wr = 1'b1;
    grp_en_wdata = 1'b1;
    @(negedge clk_sys);
    grp_en_wr = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(cnt[1], 64'h0000_0001_0000_0001, "carry past 32 bits");
    // a counter write beats the increment of the same cycle
    cnt_wr = 4'h2;
    cnt_wdata = 64'h0000_0000_0000_0100;
    @(negedge clk_sys);
    cnt_wr = 4'h0;
    check(cnt[1], 64'h0000_0000_0000_0100, "write wins");
    $display("test enable done");
    // reset in mid-run clears counters and selectors at once and sets the group enable
    rst = 1'b1;
    #1;
    check(cnt[1], 64'h0, "mid reset counter");
    check(sel[3], 6'h00, "mid reset selector");
    check(grp_en, 1'b1, "mid reset enable");
    // release again and show that counting resumes from the cleared state
    @(negedge clk_sys);
    rst = 1'b0;
    run_row('{6'h0f, 6'h00, 1'b1, 1'b0, 2'h1, 2'h0, 2'h1});
    $display("test reset done");
    close_out();
  end
endmodule // perf_event_source_encoder_bench
